/* File: tcam_pkg.sv */
// Function
// - Bass index holds four bytes: sub, pair 6/5, pair 4/3, group 7/2/1.
// - Bass index resets to 0x12 in every byte, zero gain.
// - Treble index uses the same byte layout and resets to 0x12.
// - Index 0x00 is +18 dB, one dB less per step, 0x24 is -18 dB.
// - Treble set code 0 keeps set, 1-5 select sets, 6-7 illegal.
// - Treble set fields at 26-24, 18-16, 10-8, 2-0; bits above reserved.
// - Pair 6/5 tone goes to line outs in six-channel, surround in eight.
// - AM bit 24: 0 frequency scaling, 1 rate-conversion avoidance.
// - AM bit 20 enables avoidance; bits 19:18 pick one of four sequences.
// - AM bit 17 picks the IF: 0 is 455 kHz, 1 is 262.5 kHz.
// - AM bit 16 picks tuned value coding: 0 decimal digits, 1 binary.
// - AM bits 31:25 and 23:21 are reserved and have no function.
// - Tuned frequency in low two bytes; digit mode holds four kHz digits.
// - Binary mode tuned value is 11 bits in bits 10:0, reset zero.
package tcam_pkg;

	// ==========================================================
	// Register subaddresses
	localparam logic [7:0]  ADDR_BASS_IDX   = 8'hdb;
	localparam logic [7:0]  ADDR_TREBLE_SET = 8'hdc;
	localparam logic [7:0]  ADDR_TREBLE_IDX = 8'hdd;
	localparam logic [7:0]  ADDR_AM_CTL     = 8'hde;

	// ==========================================================
	// Tone index coding
	localparam int          GROUPS          = 4;
	localparam logic [7:0]  IDX_MAX         = 8'h24;
	localparam logic [7:0]  IDX_RESET       = 8'h12;
	localparam logic [5:0]  GAIN_TOP_DB     = 6'h12;
	localparam logic [5:0]  GAIN_ZERO_DB    = 6'h00;
	localparam logic [31:0] TONE_IDX_RESET  = 32'h1212_1212;

	// ==========================================================
	// Treble filter set coding, field pitch of one byte
	localparam logic [2:0]  SET_MIN         = 3'h1;
	localparam logic [2:0]  SET_MAX         = 3'h5;
	localparam logic [2:0]  SET_RESET       = 3'h1;

	// ==========================================================
	// AM avoidance control field positions
	localparam int          AM_SRC_BIT      = 24;
	localparam int          AM_EN_BIT       = 20;
	localparam int          AM_SEQ_LO       = 18;
	localparam int          AM_IF_BIT       = 17;
	localparam int          AM_BIN_BIT      = 16;
	localparam int          FREQ_BIN_W      = 11;
	localparam logic [15:0] AM_FREQ_RESET   = 16'h0000;
	localparam logic [31:0] AM_CTL_RESET    = 32'h0000_0000;

	// ==========================================================
	// Types
	typedef logic signed [5:0] tcam_gain_t;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_BASS,
		SEL_SET,
		SEL_TREBLE,
		SEL_AM
	} tcam_sel_e;

	typedef struct packed {
		tcam_gain_t sub;
		tcam_gain_t surr;
		tcam_gain_t rear;
		tcam_gain_t front;
	} tcam_gain_s;

	typedef struct packed {
		logic [2:0] sub;
		logic [2:0] surr;
		logic [2:0] rear;
		logic [2:0] front;
	} tcam_set_s;

	typedef struct packed {
		tcam_gain_t line_bass;
		tcam_gain_t line_treble;
		tcam_gain_t surr_bass;
		tcam_gain_t surr_treble;
	} tcam_pair_s;

	typedef struct packed {
		logic        src_rate;
		logic        enable;
		logic [1:0]  seq;
		logic        if_low;
		logic        bin_fmt;
		logic [15:0] freq;
	} tcam_am_s;

endpackage

/* File: tcam_gain_field.sv */
module tcam_gain_field (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_n,
	// Write of this group's byte
	input  wire logic             wr,
	input  wire logic [7:0]       code,
	// Held index and decoded gain
	output      logic [7:0]       idx_q,
	output tcam_pkg::tcam_gain_t  gain_q
);

	// ==========================================================
	// Index and gain held together so they never disagree
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			idx_q  <= tcam_pkg::IDX_RESET;
			gain_q <= tcam_pkg::GAIN_ZERO_DB;
		end else if (wr && code <= tcam_pkg::IDX_MAX) begin
			idx_q  <= code;
			gain_q <= $signed(tcam_pkg::GAIN_TOP_DB - code[5:0]);
		end
	end

	// ==========================================================
	// Checks
	a_reset_idx: assert property (@(posedge mclk)
		!rst_n |=> idx_q == tcam_pkg::IDX_RESET && gain_q == 6'h00)
		else $error("tone index not at zero gain after reset");

	a_gain_range: assert property (@(posedge mclk) disable iff (!rst_n)
		gain_q <= 6'sh12 && gain_q >= -6'sh12)
		else $error("tone gain outside plus or minus 18 dB");

	a_bad_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		wr && code > tcam_pkg::IDX_MAX |=> $stable(idx_q) && $stable(gain_q))
		else $error("invalid index changed the tone setting");

endmodule

/* File: tcam_set_field.sv */
module tcam_set_field (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// Write of this group's set code
	input  wire logic       wr,
	input  wire logic [2:0] code,
	// Active treble filter set
	output      logic [2:0] set_q
);

	// ==========================================================
	// Code 0 and the illegal codes leave the active set alone
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			set_q <= tcam_pkg::SET_RESET;
		end else if (wr && code >= tcam_pkg::SET_MIN &&
		             code <= tcam_pkg::SET_MAX) begin
			set_q <= code;
		end
	end

	// ==========================================================
	// Checks
	a_set_take: assert property (@(posedge mclk) disable iff (!rst_n)
		wr && code inside {[3'h1:3'h5]} |=> set_q == $past(code))
		else $error("legal set code not taken");

	a_set_keep: assert property (@(posedge mclk) disable iff (!rst_n)
		wr && code inside {3'h0, 3'h6, 3'h7} |=> $stable(set_q))
		else $error("no-change or illegal set code moved the set");

endmodule

/* File: tcam_tone_regs.sv */
module tcam_tone_regs (
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	// Host register port, subaddress decoded from the serial bus
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	output      logic [31:0]           reg_rdata_q,
	output      logic                  reg_rvalid_q,
	// Output configuration, 1 for eight-channel
	input  wire logic                  chan8_mode,
	// Tone settings to the datapath
	output tcam_pkg::tcam_gain_s       bass_db_q,
	output tcam_pkg::tcam_gain_s       treble_db_q,
	output tcam_pkg::tcam_set_s        treble_set_q,
	output tcam_pkg::tcam_pair_s       pair_route_q,
	// AM interference avoidance settings
	output tcam_pkg::tcam_am_s         am_q,
	output      logic [10:0]           tuned_khz_q
);

	// ==========================================================
	// Address decode
	tcam_pkg::tcam_sel_e sel;

	always_comb begin
		case (reg_addr)
			tcam_pkg::ADDR_BASS_IDX:   sel = tcam_pkg::SEL_BASS;
			tcam_pkg::ADDR_TREBLE_SET: sel = tcam_pkg::SEL_SET;
			tcam_pkg::ADDR_TREBLE_IDX: sel = tcam_pkg::SEL_TREBLE;
			tcam_pkg::ADDR_AM_CTL:     sel = tcam_pkg::SEL_AM;
			default:                   sel = tcam_pkg::SEL_NONE;
		endcase
	end

	logic wr_bass;
	logic wr_set;
	logic wr_treble;
	logic wr_am;

	// Write strobes, one per register
	assign wr_bass   = reg_wr && sel == tcam_pkg::SEL_BASS;
	assign wr_set    = reg_wr && sel == tcam_pkg::SEL_SET;
	assign wr_treble = reg_wr && sel == tcam_pkg::SEL_TREBLE;
	assign wr_am     = reg_wr && sel == tcam_pkg::SEL_AM;

	// ==========================================================
	// Per-group tone fields
	logic [31:0] bass_idx;
	logic [31:0] treble_idx;
	logic [23:0] bass_gain;
	logic [23:0] treble_gain;
	logic [11:0] set_bus;

	// Byte g of each index register feeds group g, front group in byte 0
	for (genvar g = 0; g < tcam_pkg::GROUPS; g++) begin : g_grp
		tcam_gain_field u_bass (
			.mclk   (mclk),
			.rst_n  (rst_n),
			.wr     (wr_bass),
			.code   (reg_wdata[8*g +: 8]),
			.idx_q  (bass_idx[8*g +: 8]),
			.gain_q (bass_gain[6*g +: 6])
		);
		tcam_gain_field u_treble (
			.mclk   (mclk),
			.rst_n  (rst_n),
			.wr     (wr_treble),
			.code   (reg_wdata[8*g +: 8]),
			.idx_q  (treble_idx[8*g +: 8]),
			.gain_q (treble_gain[6*g +: 6])
		);
		tcam_set_field u_set (
			.mclk   (mclk),
			.rst_n  (rst_n),
			.wr     (wr_set),
			.code   (reg_wdata[8*g +: 3]),
			.set_q  (set_bus[3*g +: 3])
		);
	end

	// Group flops packed into the carrier structs, subwoofer first
	assign bass_db_q    = tcam_pkg::tcam_gain_s'(bass_gain);
	assign treble_db_q  = tcam_pkg::tcam_gain_s'(treble_gain);
	assign treble_set_q = tcam_pkg::tcam_set_s'(set_bus);

	// ==========================================================
	// Pair 6/5 routing by output configuration
	// The unused destination sits at 0 dB so a mode change never
	// leaves a stale boost on outputs that were just re-purposed.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pair_route_q <= '0;
		end else if (chan8_mode) begin
			pair_route_q.surr_bass   <= bass_db_q.surr;
			pair_route_q.surr_treble <= treble_db_q.surr;
			pair_route_q.line_bass   <= tcam_pkg::GAIN_ZERO_DB;
			pair_route_q.line_treble <= tcam_pkg::GAIN_ZERO_DB;
		end else begin
			pair_route_q.line_bass   <= bass_db_q.surr;
			pair_route_q.line_treble <= treble_db_q.surr;
			pair_route_q.surr_bass   <= tcam_pkg::GAIN_ZERO_DB;
			pair_route_q.surr_treble <= tcam_pkg::GAIN_ZERO_DB;
		end
	end

	// ==========================================================
	// AM avoidance control, reserved bits are not stored
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			am_q <= '0;
			am_q.freq <= tcam_pkg::AM_FREQ_RESET;
		end else if (wr_am) begin
			am_q.src_rate <= reg_wdata[tcam_pkg::AM_SRC_BIT];
			am_q.enable   <= reg_wdata[tcam_pkg::AM_EN_BIT];
			am_q.seq      <= reg_wdata[tcam_pkg::AM_SEQ_LO +: 2];
			am_q.if_low   <= reg_wdata[tcam_pkg::AM_IF_BIT];
			am_q.bin_fmt  <= reg_wdata[tcam_pkg::AM_BIN_BIT];
			am_q.freq     <= reg_wdata[15:0];
		end
	end

	// ==========================================================
	// Tuned frequency decode to plain kHz
	logic [11:0] bcd_sum;
	logic        bcd_ok;

	// Thousands is a single bit; the top of the range is 1999 kHz
	always_comb begin
		bcd_sum = {11'h000, am_q.freq[12]} * 12'h3e8 +
		          {8'h00, am_q.freq[11:8]} * 12'h064 +
		          {8'h00, am_q.freq[7:4]} * 12'h00a +
		          {8'h00, am_q.freq[3:0]};
		bcd_ok  = am_q.freq[11:8] <= 4'h9 && am_q.freq[7:4] <= 4'h9 &&
		          am_q.freq[3:0] <= 4'h9;
	end

	// A malformed digit keeps the last good value rather than
	// steering avoidance toward a frequency nobody tuned.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tuned_khz_q <= '0;
		end else if (am_q.bin_fmt) begin
			tuned_khz_q <= am_q.freq[tcam_pkg::FREQ_BIN_W-1:0];
		end else if (bcd_ok) begin
			tuned_khz_q <= bcd_sum[10:0];
		end
	end

	// ==========================================================
	// Read path, one cycle after the request
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata_q <= '0;
		end else if (reg_rd) begin
			case (sel)
				tcam_pkg::SEL_BASS:   reg_rdata_q <= bass_idx;
				tcam_pkg::SEL_TREBLE: reg_rdata_q <= treble_idx;
				tcam_pkg::SEL_SET: begin
					reg_rdata_q <= {5'h00, set_bus[11:9],
					                5'h00, set_bus[8:6],
					                5'h00, set_bus[5:3],
					                5'h00, set_bus[2:0]};
				end
				tcam_pkg::SEL_AM: begin
					reg_rdata_q <= {7'h00, am_q.src_rate, 3'h0,
					                am_q.enable, am_q.seq, am_q.if_low,
					                am_q.bin_fmt, am_q.freq};
				end
				default:              reg_rdata_q <= '0;
			endcase
		end
	end

	// Read valid strobe
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reg_rvalid_q <= 1'b0;
		end else begin
			reg_rvalid_q <= reg_rd;
		end
	end

	// ==========================================================
	// Checks
	a_bass_layout: assert property (
		@(posedge mclk) disable iff (!rst_n)
		wr_bass && reg_wdata[31:24] == 8'h00 |=>
		bass_db_q.sub == 6'sh12 && bass_idx[31:24] == 8'h00)
		else $error("subwoofer bass byte not at bits 31:24");

	a_bass_rear: assert property (
		@(posedge mclk) disable iff (!rst_n)
		wr_bass && reg_wdata[15:8] == 8'h24 |=>
		bass_db_q.rear == -6'sh12 && bass_idx[15:8] == 8'h24)
		else $error("bass index 0x24 did not give -18 dB");

	a_treble_layout: assert property (
		@(posedge mclk) disable iff (!rst_n)
		wr_treble && reg_wdata[31:24] == 8'h00 |=>
		treble_db_q.sub == 6'sh12 && treble_idx[31:24] == 8'h00)
		else $error("subwoofer treble byte not at bits 31:24");

	a_treble_gain: assert property (
		@(posedge mclk) disable iff (!rst_n)
		wr_treble && reg_wdata[7:0] == 8'h24 |=>
		treble_db_q.front == -6'sh12)
		else $error("treble index 0x24 did not give -18 dB");

	// Reset checks carry no disable so the load itself is seen
	a_tone_reset: assert property (
		@(posedge mclk)
		!rst_n |=> bass_idx == tcam_pkg::TONE_IDX_RESET &&
		treble_idx == tcam_pkg::TONE_IDX_RESET)
		else $error("tone index registers not at reset value");

	a_set_reset: assert property (
		@(posedge mclk)
		!rst_n |=> treble_set_q == {4{tcam_pkg::SET_RESET}})
		else $error("treble sets not at set 1 after reset");

	a_set_fields: assert property (
		@(posedge mclk) disable iff (!rst_n)
		wr_set && reg_wdata[26:24] == 3'h5 |=>
		treble_set_q.sub == 3'h5)
		else $error("subwoofer treble set not taken from bits 26:24");

	// Reserved set bits are never stored, so they must read as zero
	a_set_read: assert property (
		@(posedge mclk) disable iff (!rst_n)
		reg_rd && sel == tcam_pkg::SEL_SET |=>
		reg_rdata_q[31:27] == 5'h00 && reg_rdata_q[23:19] == 5'h00 &&
		reg_rdata_q[15:11] == 5'h00 && reg_rdata_q[7:3] == 5'h00)
		else $error("reserved treble set bits read nonzero");

	// Each half of pair 6/5 is watched in both configurations
	a_pair_route: assert property (
		@(posedge mclk) disable iff (!rst_n)
		chan8_mode [*2] |->
		pair_route_q.line_bass == 6'h00 &&
		pair_route_q.surr_bass == $past(bass_db_q.surr))
		else $error("pair 6/5 not routed to surround in eight-channel");

	a_pair_treble: assert property (
		@(posedge mclk) disable iff (!rst_n)
		chan8_mode [*2] |->
		pair_route_q.line_treble == 6'h00 &&
		pair_route_q.surr_treble == $past(treble_db_q.surr))
		else $error("pair 6/5 treble not routed to surround");

	a_pair_line: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(!chan8_mode) [*2] |->
		pair_route_q.surr_bass == 6'h00 &&
		pair_route_q.surr_treble == 6'h00 &&
		pair_route_q.line_bass == $past(bass_db_q.surr) &&
		pair_route_q.line_treble == $past(treble_db_q.surr))
		else $error("pair 6/5 not routed to line outs in six-channel");

	a_am_modes: assert property (
		@(posedge mclk) disable iff (!rst_n)
		wr_am |=> am_q.src_rate == $past(reg_wdata[24]) &&
		am_q.enable == $past(reg_wdata[20]) &&
		am_q.seq == $past(reg_wdata[19:18]))
		else $error("AM mode, enable or sequence not taken");

	a_am_if_fmt: assert property (
		@(posedge mclk) disable iff (!rst_n)
		wr_am |=> am_q.if_low == $past(reg_wdata[17]) &&
		am_q.bin_fmt == $past(reg_wdata[16]))
		else $error("IF or tuned coding select not taken");

	a_am_freq: assert property (
		@(posedge mclk) disable iff (!rst_n)
		wr_am |=> am_q.freq == $past(reg_wdata[15:0]))
		else $error("tuned value not stored from bits 15:0");

	a_am_reset: assert property (
		@(posedge mclk)
		!rst_n |=> am_q == '0 && tuned_khz_q == 11'h000)
		else $error("AM control or tuned value not zero after reset");

	a_am_reserved: assert property (
		@(posedge mclk) disable iff (!rst_n)
		reg_rd && sel == tcam_pkg::SEL_AM |=> reg_rvalid_q &&
		reg_rdata_q[31:25] == 7'h00 && reg_rdata_q[23:21] == 3'h0)
		else $error("AM reserved bits read nonzero");

	a_bcd_decode: assert property (
		@(posedge mclk) disable iff (!rst_n)
		wr_am && !reg_wdata[16] && reg_wdata[15:0] == 16'h1530 |=>
		##1 tuned_khz_q == 11'h5fa)
		else $error("decimal digits 1530 not decoded to 1530 kHz");

	// A bad digit must not disturb the tuning already in use
	a_bcd_hold: assert property (
		@(posedge mclk) disable iff (!rst_n)
		!am_q.bin_fmt && am_q.freq[11:8] > 4'h9 |=>
		$stable(tuned_khz_q))
		else $error("malformed decimal digit moved the tuned value");

	a_bin_decode: assert property (
		@(posedge mclk) disable iff (!rst_n)
		wr_am && reg_wdata[16] |=> ##1
		tuned_khz_q == $past(reg_wdata[10:0], 2))
		else $error("binary tuned value not taken from bits 10:0");

	// Read strobe answers exactly one cycle later, never unbidden
	a_read_valid: assert property (
		@(posedge mclk) disable iff (!rst_n)
		reg_rd |=> reg_rvalid_q)
		else $error("read not answered one cycle later");

	a_read_quiet: assert property (
		@(posedge mclk) disable iff (!rst_n)
		!reg_rd |=> !reg_rvalid_q)
		else $error("read valid raised without a read");

	a_unmapped: assert property (
		@(posedge mclk) disable iff (!rst_n)
		reg_rd && sel == tcam_pkg::SEL_NONE |=>
		reg_rdata_q == 32'h0000_0000)
		else $error("unmapped subaddress read nonzero");

endmodule

/* File: tcam_host_model.sv */
module tcam_host_model (
	// Clock
	input  wire logic        mclk,
	// Register requests
	output      logic        reg_wr,
	output      logic        reg_rd,
	output      logic [7:0]  reg_addr,
	output      logic [31:0] reg_wdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// ====
	// Quiet bus from time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
	end

	// One request, launched and held from one falling edge to the next
	task automatic xfer(input logic w, r, input logic [7:0] a,
			input logic [31:0] d);
		reg_wr = w;
		reg_rd = r;
		reg_addr = a;
		reg_wdata = d;
		@(negedge mclk);
	endtask

	// Released lines flip so stale values never look valid
	task automatic idle(input int n);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
		repeat (n) @(negedge mclk);
	endtask
endmodule

/* File: tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ====
	// Clock, stimulus and observed outputs
	logic                 mclk = 1'b0;
	logic                 rst_n = 1'b0;
	logic                 chan8_mode = 1'b0;
	logic                 reg_wr;
	logic                 reg_rd;
	logic [7:0]           reg_addr;
	logic [31:0]          reg_wdata;
	logic [31:0]          reg_rdata_q;
	logic                 reg_rvalid_q;
	tcam_pkg::tcam_gain_s bass_db_q;
	tcam_pkg::tcam_gain_s treble_db_q;
	tcam_pkg::tcam_set_s  treble_set_q;
	tcam_pkg::tcam_pair_s pair_route_q;
	tcam_pkg::tcam_am_s   am_q;
	logic [10:0]          tuned_khz_q;
	// Expected register state
	logic [31:0]          e_bass;
	logic [31:0]          e_treb;
	logic [31:0]          e_am;
	logic [31:0]          old;
	logic [31:0]          r;
	logic [31:0]          d;
	logic [11:0]          e_set;
	logic [10:0]          e_tune;
	logic [31:0]          rng = 32'h0001_1939;
	int                   error_cnt = 0;
	int                   comparisons = 0;

	always #5 mclk = ~mclk;

	tcam_host_model host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));

	tcam_tone_regs dut (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
		.chan8_mode(chan8_mode), .bass_db_q(bass_db_q),
		.treble_db_q(treble_db_q), .treble_set_q(treble_set_q),
		.pair_route_q(pair_route_q), .am_q(am_q),
		.tuned_khz_q(tuned_khz_q));

	// ====
	// Expectation helpers
	function automatic logic [31:0] next_rand();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	// Signed dB from index: 0x12 is the zero point
	function automatic logic [23:0] gains(input logic [31:0] x);
		return {6'(8'h12 - x[31:24]), 6'(8'h12 - x[23:16]),
			6'(8'h12 - x[15:8]), 6'(8'h12 - x[7:0])};
	endfunction

	// Out of range bytes leave only their own group alone
	function automatic logic [31:0] keep_idx(input logic [31:0] o, w);
		for (int i = 0; i < 4; i++)
			if (w[8*i+:8] <= 8'h24) o[8*i+:8] = w[8*i+:8];
		return o;
	endfunction

	function automatic logic [11:0] keep_set(input logic [11:0] s,
			input logic [31:0] w);
		for (int i = 0; i < 4; i++)
			if (w[8*i+:3] inside {[3'h1:3'h5]}) s[3*i+:3] = w[8*i+:3];
		return s;
	endfunction

	// Digit coding with a non-decimal digit keeps the old tuning
	function automatic logic [10:0] tune(input logic [31:0] a,
			input logic [10:0] o);
		if (a[16]) return a[10:0];
		if (a[11:8] > 9 || a[7:4] > 9 || a[3:0] > 9) return o;
		return 11'(a[12] * 1000 + a[11:8] * 100 + a[7:4] * 10 + a[3:0]);
	endfunction

	function automatic logic [31:0] rd_exp(input logic [7:0] a);
		case (a)
			tcam_pkg::ADDR_BASS_IDX:   return e_bass;
			tcam_pkg::ADDR_TREBLE_SET: return {5'h00, e_set[11:9],
				5'h00, e_set[8:6], 5'h00, e_set[5:3], 5'h00, e_set[2:0]};
			tcam_pkg::ADDR_TREBLE_IDX: return e_treb;
			tcam_pkg::ADDR_AM_CTL:     return e_am;
			default:                   return 32'h0000_0000;
		endcase
	endfunction

	task automatic upd(input logic [7:0] a, input logic [31:0] w);
		case (a)
			tcam_pkg::ADDR_BASS_IDX:   e_bass = keep_idx(e_bass, w);
			tcam_pkg::ADDR_TREBLE_SET: e_set = keep_set(e_set, w);
			tcam_pkg::ADDR_TREBLE_IDX: e_treb = keep_idx(e_treb, w);
			tcam_pkg::ADDR_AM_CTL: begin
				e_am = w & 32'h011f_ffff;
				e_tune = tune(e_am, e_tune);
			end
			default: ;
		endcase
	endtask

	// ====
	// Bus cycles, comparison and verdict
	task automatic check(input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		host.xfer(1'b1, 1'b0, a, w);
		upd(a, w);
	endtask

	task automatic rd(input logic [7:0] a);
		host.xfer(1'b0, 1'b1, a, 32'h0000_0000);
		check({31'h0000_0000, reg_rvalid_q}, 32'h0000_0001);
		check(reg_rdata_q, rd_exp(a));
	endtask

	// Settle, then compare every output and read subaddresses 0xda to 0xdf
	task automatic check_all();
		logic [23:0] b;
		logic [23:0] t;
		b = gains(e_bass);
		t = gains(e_treb);
		host.idle(3);
		check({8'h00, bass_db_q}, {8'h00, b});
		check({8'h00, treble_db_q}, {8'h00, t});
		check({20'h0_0000, treble_set_q}, {20'h0_0000, e_set});
		check({8'h00, pair_route_q}, {8'h00, chan8_mode ? {12'h000,
			b[17:12], t[17:12]} : {b[17:12], t[17:12], 12'h000}});
		check({10'h000, am_q}, {10'h000, e_am[24], e_am[20:0]});
		check({21'h00_0000, tuned_khz_q}, {21'h00_0000, e_tune});
		for (logic [7:0] a = 8'hda; a != 8'he0; a++)
			rd(a);
	endtask

	task automatic do_reset();
		rst_n = 1'b0;
		host.idle(4);
		rst_n = 1'b1;
		e_bass = tcam_pkg::TONE_IDX_RESET;
		e_treb = tcam_pkg::TONE_IDX_RESET;
		e_am = 32'h0000_0000;
		e_set = 12'h249;
		e_tune = 11'h000;
		host.idle(1);
	endtask

	task automatic give_verdict();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ====
	// Corner cases first, then seeded random traffic
	initial begin
		do_reset();
		check_all();
		wr(tcam_pkg::ADDR_BASS_IDX, 32'h0012_2412);
		check_all();
		wr(tcam_pkg::ADDR_BASS_IDX, 32'h2513_ff24);
		wr(tcam_pkg::ADDR_TREBLE_IDX, 32'h0024_4000);
		wr(tcam_pkg::ADDR_TREBLE_IDX, 32'h1224_4124);
		check_all();
		for (int c = 0; c < 8; c++) begin
			wr(tcam_pkg::ADDR_TREBLE_SET, {4{5'h1f, 3'(c)}});
			check_all();
		end
		for (int s = 0; s < 4; s++) begin
			wr(tcam_pkg::ADDR_AM_CTL, {7'h7f, 1'(s), 3'h7, 1'b1, 2'(s),
				1'(s >> 1), 1'b0, 16'h1530 + 16'(s)});
			check_all();
		end
		wr(tcam_pkg::ADDR_AM_CTL, 32'h0001_fabc);
		check_all();
		wr(tcam_pkg::ADDR_AM_CTL, 32'h0000_1a30);
		check_all();
		chan8_mode = 1'b1;
		check_all();
		old = e_bass;
		host.xfer(1'b1, 1'b1, tcam_pkg::ADDR_BASS_IDX, 32'h0102_0304);
		check(reg_rdata_q, old);
		upd(tcam_pkg::ADDR_BASS_IDX, 32'h0102_0304);
		check_all();
		for (int i = 0; i < 300; i++) begin
			r = next_rand();
			d = next_rand();
			if (r[3]) d = d & 32'h3f3f_3f3f;
			if (r[4]) d = d & 32'hffff_1999;
			chan8_mode = r[5];
			wr({5'h1b, r[2:0]}, d);
			if (r[6]) check_all();
		end
		check_all();
		do_reset();
		check_all();
		give_verdict();
	end

	// Hang guard
	initial begin
		repeat (50000) @(posedge mclk);
		error_cnt++;
		give_verdict();
	end
endmodule
